// ### verilog/pmaster_pkg.sv
// Constants and types shared by the parallel bus master sequencer
package pmaster_pkg;

  // Control low register fields
  localparam int CSF_HI  = 7;
  localparam int CSF_LO  = 6;
  // Mode high register fields
  localparam int INCREMENT_MODE_FIELD_HI = 4;
  localparam int INCREMENT_MODE_FIELD_LO = 3;
  localparam int WIDE_BIT = 2;
  localparam int MODE_HI = 1;
  localparam int MODE_LO = 0;
  // Mode low register fields
  localparam int SETUP_WAIT_FIELD_HI = 7;
  localparam int SETUP_WAIT_FIELD_LO = 6;
  localparam int STROBE_WAIT_FIELD_HI = 5;
  localparam int STROBE_WAIT_FIELD_LO = 2;
  localparam int HOLD_WAIT_FIELD_HI = 1;
  localparam int HOLD_WAIT_FIELD_LO = 0;
  // Address high byte chip select bits
  localparam int CS_ONE_POS = 6;
  localparam int CS_TWO_POS = 7;

  // Master mode codes
  localparam logic [1:0] MODE_SEP_STROBES = 2'h2;
  localparam logic [1:0] MODE_DIR_ENABLE  = 2'h3;
  // Address multiplex codes
  localparam logic [1:0] MUX_NONE    = 2'h0;
  localparam logic [1:0] MUX_PARTIAL = 2'h1;
  localparam logic [1:0] MUX_FULL    = 2'h2;
  // Increment mode codes
  localparam logic [1:0] INC_NONE = 2'h0;
  localparam logic [1:0] INC_UP   = 2'h1;
  localparam logic [1:0] INC_DOWN = 2'h2;
  // Chip select function codes
  localparam logic [1:0] CSF_NONE = 2'h0;
  localparam logic [1:0] CSF_TWO  = 2'h1;
  localparam logic [1:0] CSF_BOTH = 2'h2;

  // Reset values
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0]  DATA_RST = 8'h00;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_ALL   = 8'h02,
    ST_ALH   = 8'h04,
    ST_SETUP = 8'h08,
    ST_STRB  = 8'h10,
    ST_HOLD  = 8'h20,
    ST_NEXT  = 8'h40,
    ST_DONE  = 8'h80
  } seq_state_e;

endpackage : pmaster_pkg

// ### verilog/pmaster_if.sv
// Counter control between the sequencer and its address counter
interface pmaster_if;
  logic [15:0] addr;
  logic [1:0]  increment_mode_field;
  logic [1:0]  csf;
  logic        load;
  logic [15:0] load_val;
  logic        step;
  modport seq (output increment_mode_field, output csf, output load, output load_val, output step,
               input addr);
  modport cnt (input increment_mode_field, input csf, input load, input load_val, input step,
               output addr);
endinterface : pmaster_if

// ### verilog/pmaster_addr_counter.sv
// Address register with chip-select-aware auto increment and decrement
module pmaster_addr_counter
  import pmaster_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  pmaster_if.cnt    ctl
);

  logic [15:0] addr;
  logic [15:0] next_addr;
  logic [15:0] stepped;
  logic [15:0] keep_mask;

  assign ctl.addr = addr;

  always_comb begin
    keep_mask = 16'h0000;
    // Chip select bits are frozen; only the remaining bits count
    if (ctl.csf == CSF_TWO || ctl.csf == CSF_BOTH) begin
      keep_mask[CS_TWO_POS + 8] = 1'b1;
    end
    if (ctl.csf == CSF_BOTH) begin
      keep_mask[CS_ONE_POS + 8] = 1'b1;
    end
    case (ctl.increment_mode_field)
      INC_UP:   stepped = 16'(addr + 16'h0001);
      INC_DOWN: stepped = 16'(addr - 16'h0001);
      default:  stepped = addr;
    endcase
    next_addr = addr;
    if (ctl.load) begin
      next_addr = ctl.load_val;
    end else if (ctl.step) begin
      next_addr = (stepped & ~keep_mask) | (addr & keep_mask);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr <= ADDR_RST;
    end else begin
      addr <= next_addr;
    end
  end

endmodule // pmaster_addr_counter

// ### verilog/pmaster_sequencer.sv
// Master mode sequencer of an 8-bit parallel port
// Notes on behaviour
// - Two chip selects share pins with high address bits 6 and 7.
// - Chip select bits skip auto count; address bits take part.
// - Chip select function comes from control low bits 7:6.
// - Mode high bits 4:3 pick fixed, incrementing or decrementing address.
// - Address changes once per operation, after completion.
// - Mode low bits 7:6 give setup waits before the strobe.
// - Mode low bits 5:2 stretch the active strobe.
// - Strobe wait of zero cancels setup and hold waits.
// - Mode low bits 1:0 give hold waits after the strobe.
// - Reading low input data starts a bus read into that register.
// - Wide mode read: two bus reads, low then high byte.
// - Low data read returns previous result; software does dummy read.
// - Writing low input data starts a bus write of that byte.
// - Wide mode write: two bus writes, low then high byte.
// - Busy is set for all cycles of an operation but the last.
// - Requests while busy are ignored.
// - With interrupt enabled, pulse request after each completed cycle.
// - Mode 11 uses direction plus enable; mode 10 separate strobes.
// - Wide transfers send low byte first; byte enable marks high byte.
// - Partial mux adds a low-address cycle; full mux adds two.
module pmaster_sequencer
  import pmaster_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       enable_i,
  input  wire logic [7:0] control_low_reg_i,
  input  wire logic [7:0] mode_high_reg_i,
  input  wire logic [7:0] mode_low_reg_i,
  input  wire logic [1:0] addr_mux_i,
  input  wire logic       irq_enable_i,
  input  wire logic       addr_load_i,
  input  wire logic [15:0] addr_load_val_i,
  input  wire logic       data_rd_i,
  input  wire logic       data_wr_i,
  input  wire logic [7:0] data_wr_low_i,
  input  wire logic [7:0] data_wr_high_i,
  input  wire logic [7:0] port_data_bus_i,
  output logic [7:0]      port_data_bus_o,
  output logic            port_data_bus_oe_o,
  output logic [15:0]     address_o,
  output logic            chip_select_one_o,
  output logic            chip_select_two_o,
  output logic            read_strobe_o,
  output logic            write_strobe_o,
  output logic            enable_strobe_o,
  output logic            byte_enable_strobe_o,
  output logic            addr_latch_low_o,
  output logic            addr_latch_high_o,
  output logic [7:0]      input_data_low_reg_o,
  output logic [7:0]      input_data_high_reg_o,
  output logic            busy_o,
  output logic            irq_o
);

  pmaster_if ctl ();

  pmaster_addr_counter i_pmaster_addr_counter (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ctl       (ctl.cnt)
  );

  seq_state_e  state;
  seq_state_e  next_state;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic        is_read;
  logic        next_is_read;
  logic        hi_byte;
  logic        next_hi_byte;
  logic        wide;
  logic        next_wide;
  logic [1:0]  mode;
  logic [1:0]  next_mode;
  logic [1:0]  mux;
  logic [1:0]  next_mux;
  logic [1:0]  setup_wait_field;
  logic [1:0]  next_setup_wait_field;
  logic [3:0]  strobe_wait_field;
  logic [3:0]  next_strobe_wait_field;
  logic [1:0]  hold_wait_field;
  logic [1:0]  next_hold_wait_field;
  logic [7:0]  wr_hi;
  logic [7:0]  next_wr_hi;
  logic [7:0]  wr_lo;
  logic [7:0]  next_wr_lo;
  logic [7:0]  din_lo;
  logic [7:0]  next_din_lo;
  logic [7:0]  din_hi;
  logic [7:0]  next_din_hi;
  logic        busy;
  logic        next_busy;
  logic        irq;
  logic        next_irq;
  logic        start;
  logic        master;
  logic [1:0]  csf;
  logic        last_cyc;

  // Output pin registers
  logic [7:0]  pd_o;
  logic [7:0]  next_pd_o;
  logic        pd_oe;
  logic        next_pd_oe;
  logic [15:0] addr_o;
  logic [15:0] next_addr_o;
  logic        cs1;
  logic        next_cs1;
  logic        cs2;
  logic        next_cs2;
  logic        rd_s;
  logic        next_rd_s;
  logic        wr_s;
  logic        next_wr_s;
  logic        en_s;
  logic        next_en_s;
  logic        be_s;
  logic        next_be_s;
  logic        all_s;
  logic        next_all_s;
  logic        alh_s;
  logic        next_alh_s;

  assign master = enable_i && mode_high_reg_i[MODE_HI];
  assign csf    = control_low_reg_i[CSF_HI:CSF_LO];
  // Busy masks new requests; outside the idle and done states they are dropped too
  assign start  = master && !busy && (state == ST_IDLE || state == ST_DONE)
                  && (data_rd_i || data_wr_i);

  assign ctl.increment_mode_field     = mode_high_reg_i[INCREMENT_MODE_FIELD_HI:INCREMENT_MODE_FIELD_LO];
  assign ctl.csf      = csf;
  // Loads only between transfers; a load in a start cycle moves the address after the first transfer cycle
  assign ctl.load     = addr_load_i && !busy && (state == ST_IDLE || state == ST_DONE);
  assign ctl.load_val = addr_load_val_i;
  // Step as the final byte completes, ready for a start in the done cycle
  assign ctl.step     = (state == ST_NEXT) && !(wide && !hi_byte) && master;

  // Phase after address latching: setup, or straight to strobe
  function automatic seq_state_e after_addr(input logic [1:0] wb, input logic [3:0] wm);
    if (wm != 4'h0 && wb != 2'h0) begin
      after_addr = ST_SETUP;
    end else begin
      after_addr = ST_STRB;
    end
  endfunction

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_is_read = is_read;
    next_hi_byte = hi_byte;
    next_wide    = wide;
    next_mode    = mode;
    next_mux     = mux;
    next_setup_wait_field   = setup_wait_field;
    next_strobe_wait_field   = strobe_wait_field;
    next_hold_wait_field   = hold_wait_field;
    next_wr_lo   = wr_lo;
    next_wr_hi   = wr_hi;
    next_din_lo  = din_lo;
    next_din_hi  = din_hi;
    next_irq     = 1'b0;
    case (state)
      ST_IDLE, ST_DONE: begin
        next_state = ST_IDLE;
        if (start) begin
          next_is_read = data_rd_i;
          next_hi_byte = 1'b0;
          next_wide    = mode_high_reg_i[WIDE_BIT];
          next_mode    = mode_high_reg_i[MODE_HI:MODE_LO];
          next_mux     = addr_mux_i;
          next_setup_wait_field   = mode_low_reg_i[SETUP_WAIT_FIELD_HI:SETUP_WAIT_FIELD_LO];
          next_strobe_wait_field   = mode_low_reg_i[STROBE_WAIT_FIELD_HI:STROBE_WAIT_FIELD_LO];
          next_hold_wait_field   = mode_low_reg_i[HOLD_WAIT_FIELD_HI:HOLD_WAIT_FIELD_LO];
          next_wr_lo   = data_wr_low_i;
          next_wr_hi   = data_wr_high_i;
          next_cnt     = 4'h0;
          if (addr_mux_i == MUX_PARTIAL || addr_mux_i == MUX_FULL) begin
            next_state = ST_ALL;
          end else begin
            next_state = after_addr(mode_low_reg_i[SETUP_WAIT_FIELD_HI:SETUP_WAIT_FIELD_LO],
                                    mode_low_reg_i[STROBE_WAIT_FIELD_HI:STROBE_WAIT_FIELD_LO]);
          end
        end
      end
      ST_ALL: begin
        next_state = (mux == MUX_FULL) ? ST_ALH : after_addr(setup_wait_field, strobe_wait_field);
      end
      ST_ALH: begin
        next_state = after_addr(setup_wait_field, strobe_wait_field);
      end
      ST_SETUP: begin
        next_cnt = 4'(cnt + 4'h1);
        if (cnt == {2'h0, setup_wait_field} - 4'h1) begin
          next_cnt   = 4'h0;
          next_state = ST_STRB;
        end
      end
      ST_STRB: begin
        // One base strobe cycle plus strobe_wait_field stretch cycles
        next_cnt = 4'(cnt + 4'h1);
        if (cnt == strobe_wait_field) begin
          next_cnt = 4'h0;
          if (is_read) begin
            if (hi_byte) begin
              next_din_hi = port_data_bus_i;
            end else begin
              next_din_lo = port_data_bus_i;
            end
          end
          if (strobe_wait_field != 4'h0 && hold_wait_field != 2'h0) begin
            next_state = ST_HOLD;
          end else begin
            next_state = ST_NEXT;
          end
        end
      end
      ST_HOLD: begin
        next_cnt = 4'(cnt + 4'h1);
        if (cnt == {2'h0, hold_wait_field} - 4'h1) begin
          next_cnt   = 4'h0;
          next_state = ST_NEXT;
        end
      end
      ST_NEXT: begin
        if (wide && !hi_byte) begin
          next_hi_byte = 1'b1;
          next_state   = after_addr(setup_wait_field, strobe_wait_field);
        end else begin
          next_state = ST_DONE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Completion pulse shows in the cycle after the last strobe or hold cycle
    next_irq = irq_enable_i && (next_state == ST_NEXT);
    // Last bus cycle of the whole op: final strobe or hold cycle of last byte
    last_cyc = (!next_wide || next_hi_byte)
               && ((next_state == ST_STRB && next_cnt == next_strobe_wait_field
                    && (next_strobe_wait_field == 4'h0 || next_hold_wait_field == 2'h0))
                   || (next_state == ST_HOLD
                       && next_cnt == {2'h0, next_hold_wait_field} - 4'h1));
    // Single-cycle ops never show busy; the idle/done state check still drops their triggers
    next_busy = (next_state != ST_IDLE) && (next_state != ST_DONE) && !last_cyc
                && (next_state != ST_NEXT || (next_wide && !next_hi_byte));
  end

  // Pin drive: address and selects held steady for the whole transfer unless an address load lands in its start cycle
  always_comb begin
    logic in_cyc;
    logic strb;
    in_cyc = (next_state != ST_IDLE) && (next_state != ST_DONE);
    strb   = (next_state == ST_STRB);
    next_addr_o = ctl.addr;
    next_cs1 = 1'b0;
    next_cs2 = 1'b0;
    if (csf == CSF_BOTH) begin
      next_addr_o[CS_ONE_POS + 8] = 1'b0;
      next_cs1 = in_cyc && ctl.addr[CS_ONE_POS + 8];
    end
    if (csf == CSF_TWO || csf == CSF_BOTH) begin
      next_addr_o[CS_TWO_POS + 8] = 1'b0;
      next_cs2 = in_cyc && ctl.addr[CS_TWO_POS + 8];
    end
    next_all_s = (next_state == ST_ALL);
    next_alh_s = (next_state == ST_ALH);
    next_pd_o  = next_hi_byte ? next_wr_hi : next_wr_lo;
    next_pd_oe = in_cyc && !next_is_read;
    if (next_state == ST_ALL) begin
      next_pd_o  = next_addr_o[7:0];
      next_pd_oe = 1'b1;
    end else if (next_state == ST_ALH) begin
      next_pd_o  = next_addr_o[15:8];
      next_pd_oe = 1'b1;
    end
    next_be_s = in_cyc && next_hi_byte;
    next_rd_s = 1'b0;
    next_wr_s = 1'b0;
    next_en_s = 1'b0;
    if (next_mode == MODE_DIR_ENABLE) begin
      // Direction line on the read pin stays high for the whole read
      next_rd_s = in_cyc && next_is_read;
      next_en_s = strb;
    end else begin
      next_rd_s = strb && next_is_read;
      next_wr_s = strb && !next_is_read;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state   <= ST_IDLE;
      cnt     <= 4'h0;
      is_read <= 1'b0;
      hi_byte <= 1'b0;
      wide    <= 1'b0;
      mode    <= MODE_SEP_STROBES;
      mux     <= MUX_NONE;
      setup_wait_field   <= 2'h0;
      strobe_wait_field   <= 4'h0;
      hold_wait_field   <= 2'h0;
      wr_lo   <= DATA_RST;
      wr_hi   <= DATA_RST;
      din_lo  <= DATA_RST;
      din_hi  <= DATA_RST;
      busy    <= 1'b0;
      irq     <= 1'b0;
      pd_o    <= DATA_RST;
      pd_oe   <= 1'b0;
      addr_o  <= ADDR_RST;
      cs1     <= 1'b0;
      cs2     <= 1'b0;
      rd_s    <= 1'b0;
      wr_s    <= 1'b0;
      en_s    <= 1'b0;
      be_s    <= 1'b0;
      all_s   <= 1'b0;
      alh_s   <= 1'b0;
    end else begin
      state   <= next_state;
      cnt     <= next_cnt;
      is_read <= next_is_read;
      hi_byte <= next_hi_byte;
      wide    <= next_wide;
      mode    <= next_mode;
      mux     <= next_mux;
      setup_wait_field   <= next_setup_wait_field;
      strobe_wait_field   <= next_strobe_wait_field;
      hold_wait_field   <= next_hold_wait_field;
      wr_lo   <= next_wr_lo;
      wr_hi   <= next_wr_hi;
      din_lo  <= next_din_lo;
      din_hi  <= next_din_hi;
      busy    <= next_busy;
      irq     <= next_irq;
      pd_o    <= next_pd_o;
      pd_oe   <= next_pd_oe;
      addr_o  <= next_addr_o;
      cs1     <= next_cs1;
      cs2     <= next_cs2;
      rd_s    <= next_rd_s;
      wr_s    <= next_wr_s;
      en_s    <= next_en_s;
      be_s    <= next_be_s;
      all_s   <= next_all_s;
      alh_s   <= next_alh_s;
    end
  end

  assign port_data_bus_o       = pd_o;
  assign port_data_bus_oe_o    = pd_oe;
  assign address_o             = addr_o;
  assign chip_select_one_o     = cs1;
  assign chip_select_two_o     = cs2;
  assign read_strobe_o         = rd_s;
  assign write_strobe_o        = wr_s;
  assign enable_strobe_o       = en_s;
  assign byte_enable_strobe_o  = be_s;
  assign addr_latch_low_o      = all_s;
  assign addr_latch_high_o     = alh_s;
  assign input_data_low_reg_o  = din_lo;
  assign input_data_high_reg_o = din_hi;
  assign busy_o                = busy;
  assign irq_o                 = irq;

endmodule // pmaster_sequencer

// ### verif/pmaster_sequencer_monitor.sv
// Port checker of the parallel bus master sequencer
module pmaster_sequencer_monitor
  import pmaster_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  control_low_reg_i,
  input  wire logic [7:0]  mode_high_reg_i,
  input  wire logic [7:0]  mode_low_reg_i,
  input  wire logic [1:0]  addr_mux_i,
  input  wire logic [7:0]  port_data_bus_o,
  input  wire logic        port_data_bus_oe_o,
  input  wire logic [15:0] address_o,
  input  wire logic        chip_select_one_o,
  input  wire logic        chip_select_two_o,
  input  wire logic        read_strobe_o,
  input  wire logic        write_strobe_o,
  input  wire logic        enable_strobe_o,
  input  wire logic        byte_enable_strobe_o,
  input  wire logic        addr_latch_low_o,
  input  wire logic        addr_latch_high_o,
  input  wire logic        irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic sx;
  // Direction line in mode 11 is no strobe
  assign sx = write_strobe_o || enable_strobe_o || (read_strobe_o && !mode_high_reg_i[MODE_LO]);
  a_strobe_excl: assert property (!(read_strobe_o && write_strobe_o))
    else $error("read and write strobes together");
  a_addr_stable: assert property ($past(sx) && sx |-> $stable({address_o,
    chip_select_one_o, chip_select_two_o})) else $error("address moved in strobe");
  a_strobe_one: assert property ($rose(write_strobe_o) && mode_low_reg_i[5:2] == 4'h0
    |=> !write_strobe_o) else $error("strobe too long");
  a_strobe_len: assert property ($rose(write_strobe_o) && mode_low_reg_i[5:2] == 4'h3
    |-> write_strobe_o [*4] ##1 !write_strobe_o) else $error("strobe length wrong");
  a_irq_pulse: assert property (irq_o |=> !irq_o)
    else $error("irq longer than one cycle");
  a_latch_low: assert property (addr_latch_low_o |-> port_data_bus_oe_o &&
    port_data_bus_o == address_o[7:0] ##1 !addr_latch_low_o) else $error("low latch wrong");
  a_latch_high: assert property (addr_latch_low_o && addr_mux_i == MUX_FULL |=>
    addr_latch_high_o && port_data_bus_o == address_o[15:8]) else $error("high latch wrong");
  a_be_wide: assert property (byte_enable_strobe_o |-> mode_high_reg_i[WIDE_BIT])
    else $error("byte enable in narrow mode");
  a_cs_forced: assert property (sx && control_low_reg_i[7:6] == CSF_BOTH
    |-> address_o[15:14] == 2'h0) else $error("chip select bits on address");
  c_wide_read: cover property (byte_enable_strobe_o && read_strobe_o);
  c_latch_high: cover property (addr_latch_high_o);
  c_enable_write: cover property (enable_strobe_o && !read_strobe_o);
endmodule // pmaster_sequencer_monitor

bind pmaster_sequencer pmaster_sequencer_monitor i_pmaster_sequencer_monitor (
  .clk_sys_i, .rst_n_i, .control_low_reg_i, .mode_high_reg_i, .mode_low_reg_i,
  .addr_mux_i, .port_data_bus_o, .port_data_bus_oe_o, .address_o, .chip_select_one_o,
  .chip_select_two_o, .read_strobe_o, .write_strobe_o, .enable_strobe_o,
  .byte_enable_strobe_o, .addr_latch_low_o, .addr_latch_high_o, .irq_o
);

// ### verif/pmaster_mem_model.sv
// Behavioural byte memory on the far side of the parallel port
module pmaster_mem_model (
  input  wire logic        clk_sys_i,
  input  wire logic        dir_en_i,
  input  wire logic [15:0] address_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  input  wire logic        en_i,
  input  wire logic        be_i,
  input  wire logic        oe_i,
  input  wire logic [7:0]  data_i,
  output logic [7:0]       data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem[256];
  logic [7:0] last = 8'h00;
  logic       rd;
  logic       wr;
  logic [7:0] idx;
  assign rd = dir_en_i ? (en_i && rd_i) : rd_i;
  assign wr = dir_en_i ? (en_i && !rd_i) : wr_i;
  assign idx = {be_i, address_i[6:0]};
  // Released bus shows the inverse so a late sample fails
  assign data_o = rd ? mem[idx] : ~last;
  initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'h3c;
  always @(posedge clk_sys_i) begin
    if (rd) last <= mem[idx];
    if (wr && oe_i) mem[idx] <= data_i;
  end
endmodule // pmaster_mem_model

// ### verif/test_pmaster_sequencer.sv
// Self-checking bench of the parallel bus master sequencer
`define CHK(nm, ex, sn) begin total_checks++; if ((sn) !== (ex)) begin err_count++; \
  $display("BAD %s expected %h seen %h", nm, ex, sn); end end
module test_pmaster_sequencer
  import pmaster_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, enable_i = 1'b1, irq_enable_i = 1'b1;
  logic        addr_load_i = 1'b0, data_rd_i = 1'b0, data_wr_i = 1'b0;
  logic [7:0]  control_low_reg_i = 8'h00, mode_high_reg_i = 8'h00, mode_low_reg_i = 8'h00;
  logic [7:0]  data_wr_low_i = 8'h00, data_wr_high_i = 8'h00, port_data_bus_i;
  logic [1:0]  addr_mux_i = 2'h0, mux, increment_mode_field, csf, b, he;
  logic [15:0] addr_load_val_i = 16'h0000, address_o, seed = 16'hdc34, addr, cnt;
  logic [7:0]  port_data_bus_o, input_data_low_reg_o, input_data_high_reg_o, wr_seen;
  logic        port_data_bus_oe_o, chip_select_one_o, chip_select_two_o, read_strobe_o;
  logic        write_strobe_o, enable_strobe_o, byte_enable_strobe_o, addr_latch_low_o;
  logic        addr_latch_high_o, busy_o, irq_o, m, wide;
  logic [3:0]  mw;
  logic [9:0]  exp_q[$], e;
  logic [7:0]  shadow[256];
  logic [15:0] tbl[3] = '{16'h1c20, 16'ha8d2, 16'h545d};
  int          err_count = 0, total_checks = 0, cyc = 0;

  pmaster_sequencer i_pmaster_sequencer (
    .clk_sys_i, .rst_n_i, .enable_i, .control_low_reg_i, .mode_high_reg_i, .mode_low_reg_i,
    .addr_mux_i, .irq_enable_i, .addr_load_i, .addr_load_val_i, .data_rd_i, .data_wr_i,
    .data_wr_low_i, .data_wr_high_i, .port_data_bus_i, .port_data_bus_o, .port_data_bus_oe_o,
    .address_o, .chip_select_one_o, .chip_select_two_o, .read_strobe_o, .write_strobe_o,
    .enable_strobe_o, .byte_enable_strobe_o, .addr_latch_low_o, .addr_latch_high_o,
    .input_data_low_reg_o, .input_data_high_reg_o, .busy_o, .irq_o);
  pmaster_mem_model i_pmaster_mem_model (
    .clk_sys_i, .dir_en_i(mode_high_reg_i[MODE_LO]), .address_i(address_o),
    .rd_i(read_strobe_o), .wr_i(write_strobe_o), .en_i(enable_strobe_o),
    .be_i(byte_enable_strobe_o), .oe_i(port_data_bus_oe_o), .data_i(port_data_bus_o),
    .data_o(port_data_bus_i));

  always #5 clk_sys_i = ~clk_sys_i;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Each irq retires the oldest expected byte
  always @(posedge clk_sys_i) begin
    if (rst_n_i && irq_o === 1'b1) begin
      if (exp_q.size() == 0) `CHK("irq", 1'b0, irq_o)
      else begin
        e = exp_q.pop_front();
        `CHK("data", e[7:0], e[9] ? (e[8] ? input_data_high_reg_o : input_data_low_reg_o) : wr_seen)
      end
    end
    if (port_data_bus_oe_o === 1'b1 && (write_strobe_o || enable_strobe_o && !read_strobe_o))
      wr_seen <= port_data_bus_o;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("BAD run expected end seen hang");
      summarize();
    end
  end

  task automatic cfg(input logic [15:0] r);
    m = r[0];
    mux = (r[2:1] == 2'h3) ? MUX_NONE : r[2:1];
    {increment_mode_field, he, mw, b, wide} = r[13:3];
    csf = (r[15:14] == 2'h3) ? CSF_NONE : r[15:14];
    cnt = (csf == CSF_BOTH) ? 16'h3fff : (csf == CSF_TWO) ? 16'h7fff : 16'hffff;
    mode_high_reg_i = {3'h0, increment_mode_field, wide, 1'b1, m};
    mode_low_reg_i = {b, mw, he};
    control_low_reg_i = {csf, 6'h00};
    addr_mux_i = mux;
    addr = ~r;
    addr_load_val_i = addr;
    addr_load_i = 1'b1;
    @(posedge clk_sys_i);
    #1 addr_load_i = 1'b0;
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic op(input logic rd);
    int n;
    int xn;
    logic [7:0] ix;
    seed = lfsr(seed);
    ix = {1'b0, addr[6:0]};
    xn = (mux == MUX_FULL ? 2 : mux == MUX_PARTIAL ? 1 : 0) + (mw != 0 ? b + mw + he + 2 : 2);
    exp_q.push_back({rd, 1'b0, rd ? shadow[ix] : seed[7:0]});
    if (wide) exp_q.push_back({rd, 1'b1, rd ? shadow[ix | 8'h80] : seed[15:8]});
    if (!rd) {shadow[ix | 8'h80], shadow[ix]} = wide ? seed : {shadow[ix | 8'h80], seed[7:0]};
    data_rd_i = rd;
    data_wr_i = !rd;
    {data_wr_high_i, data_wr_low_i} = seed;
    @(posedge clk_sys_i);
    #1 data_rd_i = 1'b0;
    // Trigger while busy must be dropped
    data_wr_i = busy_o;
    data_wr_low_i = ~seed[7:0];
    `CHK("address", addr & cnt, address_o)
    `CHK("cs_two", csf != CSF_NONE && addr[15], chip_select_two_o)
    `CHK("cs_one", csf == CSF_BOTH && addr[14], chip_select_one_o)
    `CHK("busy", wide || mux != MUX_NONE || mw != 4'h0, busy_o)
    if (!wide && mux == MUX_NONE && mw == 4'h0) begin
      `CHK("strobe", 1'b1, m ? enable_strobe_o : rd ? read_strobe_o : write_strobe_o)
    end
    n = 1;
    while (irq_o !== 1'b1 && n < 200) begin
      @(posedge clk_sys_i);
      #1 data_wr_i = 1'b0;
      n++;
    end
    if (!wide) `CHK("cycles", xn, n)
    while ((exp_q.size() != 0 || busy_o !== 1'b0) && n < 200) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
    if (increment_mode_field == INC_UP) addr = (addr & ~cnt) | ((addr + 16'h1) & cnt);
    else if (increment_mode_field == INC_DOWN) addr = (addr & ~cnt) | ((addr - 16'h1) & cnt);
  endtask

  initial begin
    foreach (shadow[i]) shadow[i] = 8'(i) ^ 8'h3c;
    repeat (4) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    foreach (tbl[i]) begin
      cfg(tbl[i]);
      op(1'b0);
      op(1'b0);
      op(1'b1);
      $display("table test %0d finished", i);
    end
    repeat (30) begin
      seed = lfsr(seed);
      cfg(seed);
      op(seed[12]);
      op(seed[0]);
    end
    $display("random test finished");
    mode_high_reg_i[MODE_HI:MODE_LO] = 2'h0;
    data_wr_i = 1'b1;
    @(posedge clk_sys_i);
    #1 data_wr_i = 1'b0;
    repeat (20) @(posedge clk_sys_i);
    #1;
    `CHK("busy", 1'b0, busy_o)
    `CHK("address", addr & cnt, address_o)
    `CHK("pending", 0, exp_q.size())
    $display("idle test finished");
    summarize();
  end
endmodule // test_pmaster_sequencer
